// >>> hcu_cfg.svh
// Constants for the hidden clock unlock host: timing, widths and pattern
`ifndef HCU_CFG_SVH
`define HCU_CFG_SVH

`define HCU_CLK_NS        8
`define HCU_ADDR_W        17
`define HCU_DATA_W        8
`define HCU_SEQ_BITS      64
`define HCU_BITS_PER_REG  8
`define HCU_FIFO_DEPTH    16
// Least strobe width and least recovery between cycles, in ns
`define HCU_STROBE_NS     85
`define HCU_GAP_NS        20
// Power-up recovery delay, least value, in ns (1.5 ms)
`define HCU_REC_NS        1500000
// Least times round up to whole clock cycles
`define HCU_STROBE_CYC    ((`HCU_STROBE_NS + `HCU_CLK_NS - 1) / `HCU_CLK_NS)
`define HCU_GAP_CYC       ((`HCU_GAP_NS + `HCU_CLK_NS - 1) / `HCU_CLK_NS)
`define HCU_REC_CYC       ((`HCU_REC_NS + `HCU_CLK_NS - 1) / `HCU_CLK_NS)
`define HCU_TIMER_W       18
// Comparison pattern default; arbitrary value, must match the device
`define HCU_PATTERN       64'h0123_4567_89AB_CDEF

`endif

// >>> hcu_pkg.sv
// Types for the hidden clock unlock host
`include "hcu_cfg.svh"

package hcu_pkg;

	typedef enum logic [1:0] {
		HCU_IDLE   = 2'b00,
		HCU_STROBE = 2'b01,
		HCU_GAP    = 2'b10
	} hcu_state_t;

	typedef enum logic [1:0] {
		HCU_OPEN   = 2'b00,
		HCU_UNLOCK = 2'b01,
		HCU_XFER   = 2'b10
	} hcu_stage_t;

	typedef struct packed {
		hcu_state_t                st;
		hcu_stage_t                stage;
		logic [`HCU_TIMER_W-1:0]   timer;
		logic [5:0]                bitIdx;
		logic                      recovered;
		logic                      isWrite;
		logic                      last;
		logic [`HCU_DATA_W-1:0]    shift;
		logic [`HCU_ADDR_W-1:0]    addr;
		logic                      ceN;
		logic                      oeN;
		logic                      weN;
		logic [`HCU_DATA_W-1:0]    dqOut;
		logic                      dqOe;
		logic [`HCU_DATA_W-1:0]    rdData;
		logic                      rdValid;
		logic                      done;
		logic                      abort;
	} hcu_host_t;

endpackage : hcu_pkg

// >>> hcu_host.sv
// Host controller that unlocks and transfers the hidden clock registers
`timescale 1ns/1ps
`default_nettype none
`include "hcu_cfg.svh"

// Write-data FIFO, flip-flop storage, valid/ready on both sides
module hcu_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wp;
		logic [AW:0]                 rp;
	} hcu_fifo_st_t;

	hcu_fifo_st_t q;
	hcu_fifo_st_t d;
	logic         full;
	logic         empty;

	// Extra pointer bit tells full from empty
	assign empty    = (q.wp == q.rp);
	assign full     = (q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]);
	assign inReady  = !full;
	assign outValid = !empty;
	assign outData  = q.mem[q.rp[AW-1:0]];

	// Push and pop
	always_comb begin
		d = q;
		if (inValid && !full) begin
			d.mem[q.wp[AW-1:0]] = inData;
			d.wp = q.wp + (AW+1)'(1);
		end
		if (outReady && !empty) begin
			d.rp = q.rp + (AW+1)'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : hcu_fifo

// How it works
// - Unlock with 64 writes carrying pattern bits.
// - Each attempt opens with a CE/OE read.
// - All writes go to one scratch address.
// - Wait recovery delay after power returns.
// - Chip select forced high the moment power fails.
// - Pattern sent least significant bit first.
// - Eight BCD registers, bit 0 to 7.
module hcu_host
	import hcu_pkg::*;
#(
	parameter logic [`HCU_SEQ_BITS-1:0] UnlockPattern  = `HCU_PATTERN,
	parameter int                       RecoveryCycles = `HCU_REC_CYC
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   powerOk,
	input  wire logic [`HCU_ADDR_W-1:0] scratchAddr,
	input  wire logic                   cmdValid,
	input  wire logic                   cmdWrite,
	output logic                        cmdReady,
	input  wire logic [`HCU_DATA_W-1:0] wrData,
	input  wire logic                   wrValid,
	output logic                        wrReady,
	output logic      [`HCU_DATA_W-1:0] rdData,
	output logic                        rdValid,
	output logic                        busy,
	output logic                        done,
	output logic                        abort,
	output logic                        ceN,
	output logic                        oeN,
	output logic                        weN,
	output logic      [`HCU_ADDR_W-1:0] addr,
	output logic      [`HCU_DATA_W-1:0] dqOut,
	output logic                        dqOe,
	input  wire logic [`HCU_DATA_W-1:0] dqIn
);
	localparam logic [`HCU_TIMER_W-1:0] StrobeLoad = `HCU_TIMER_W'(`HCU_STROBE_CYC - 1);
	localparam logic [`HCU_TIMER_W-1:0] GapLoad    = `HCU_TIMER_W'(`HCU_GAP_CYC - 1);
	localparam logic [`HCU_TIMER_W-1:0] RecLoad    = `HCU_TIMER_W'(RecoveryCycles);

	hcu_host_t              q;
	hcu_host_t              d;
	logic [`HCU_DATA_W-1:0] fifoData;
	logic                   fifoValid;
	logic                   fifoPop;

	// Source stalls on wrReady once sixteen bytes wait
	hcu_fifo #(
		.WIDTH (`HCU_DATA_W),
		.DEPTH (`HCU_FIFO_DEPTH)
	) u_hcu_fifo (
		.clk      (clk),
		.rst_n    (rst_n),
		.inData   (wrData),
		.inValid  (wrValid),
		.inReady  (wrReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (fifoPop)
	);

	// Ends the strobe; every cycle gets the same width and recovery
	function automatic hcu_host_t endStrobe(input hcu_host_t s);
		hcu_host_t r;
		r       = s;
		r.ceN   = 1'b1; // Rising select ends the write here
		r.oeN   = 1'b1;
		r.weN   = 1'b1;
		r.st    = HCU_GAP;
		r.timer = GapLoad;
		return r;
	endfunction : endStrobe

	// Opens one bus cycle, read or write
	function automatic hcu_host_t openCycle(input hcu_host_t s, input logic wr,
			input logic bitVal);
		hcu_host_t r;
		r       = s;
		r.ceN   = 1'b0;
		r.oeN   = wr;
		r.weN   = !wr;
		r.dqOut = {{(`HCU_DATA_W-1){1'b0}}, bitVal}; // Only bit zero matters
		r.dqOe  = wr;
		r.st    = HCU_STROBE;
		r.timer = StrobeLoad;
		return r;
	endfunction : openCycle

	// Command is taken only with power good and recovery spent
	assign cmdReady = (q.st == HCU_IDLE) && q.recovered && powerOk;
	assign busy     = (q.st != HCU_IDLE);
	// Select forced high the moment power fails, no clock lag
	assign ceN      = q.ceN | !powerOk;
	assign oeN      = q.oeN;
	assign weN      = q.weN;
	assign addr     = q.addr;
	assign dqOut    = q.dqOut;
	assign dqOe     = q.dqOe & powerOk;
	assign rdData   = q.rdData;
	assign rdValid  = q.rdValid;
	assign done     = q.done;
	assign abort    = q.abort;

	// Sequencer: opening read, 64 unlock writes, 64 transfer cycles
	always_comb begin
		d         = q;
		d.rdValid = 1'b0;
		d.done    = 1'b0;
		d.abort   = 1'b0;
		fifoPop   = 1'b0;
		if (!powerOk) begin
			// Drop everything and restart the recovery wait
			d.st        = HCU_IDLE;
			d.recovered = 1'b0;
			d.timer     = RecLoad;
			d.ceN       = 1'b1;
			d.oeN       = 1'b1;
			d.weN       = 1'b1;
			d.dqOe      = 1'b0;
			d.last      = 1'b0;
			d.abort     = (q.st != HCU_IDLE);
		end else begin
			unique case (q.st)
				HCU_IDLE: begin
					if (!q.recovered) begin
						if (q.timer == '0) begin
							d.recovered = 1'b1;
						end else begin
							d.timer = q.timer - `HCU_TIMER_W'(1);
						end
					end else if (cmdValid) begin
						// Every command unlocks anew at the scratch word
						d         = openCycle(q, 1'b0, 1'b0); // Opening read
						d.isWrite = cmdWrite;
						d.stage   = HCU_OPEN;
						d.bitIdx  = '0;
						d.addr    = scratchAddr;
					end
				end
				HCU_STROBE: begin
					if (q.timer != '0) begin
						d.timer = q.timer - `HCU_TIMER_W'(1);
					end else begin
						d = endStrobe(q);
						unique case (q.stage)
							HCU_OPEN: begin
								d.stage  = HCU_UNLOCK;
								d.bitIdx = '0;
							end
							HCU_UNLOCK: begin
								d.bitIdx = q.bitIdx + 6'd1;
								if (q.bitIdx == 6'd63) begin
									d.stage = HCU_XFER; // Pattern done, clock opens
								end
							end
							default: begin
								if (!q.isWrite) begin
									// Sample bit zero, LSB first into the byte
									d.shift = {dqIn[0], q.shift[`HCU_DATA_W-1:1]};
									if (q.bitIdx[2:0] == 3'd7) begin
										d.rdData  = {dqIn[0], q.shift[`HCU_DATA_W-1:1]};
										d.rdValid = 1'b1;
									end
								end
								d.bitIdx = q.bitIdx + 6'd1;
								d.last   = (q.bitIdx == 6'd63);
							end
						endcase
					end
				end
				default: begin
					if (q.timer != '0) begin
						d.timer = q.timer - `HCU_TIMER_W'(1);
					end else begin
						d.dqOe = 1'b0; // Data held through recovery for hold time
						if (q.last) begin
							d.st   = HCU_IDLE;
							d.last = 1'b0;
							d.done = 1'b1; // Device back on SRAM routing
						end else if (q.stage == HCU_UNLOCK) begin
							// Pattern bit by pointer, LSB first
							d = openCycle(q, 1'b1, UnlockPattern[q.bitIdx]);
						end else if (!q.isWrite) begin
							d = openCycle(q, 1'b0, 1'b0);
						end else if (q.bitIdx[2:0] != 3'd0) begin
							d = openCycle(q, 1'b1, q.shift[q.bitIdx[2:0]]);
						end else if (fifoValid) begin
							// New byte per register; stalls here while FIFO empty
							fifoPop = 1'b1;
							d       = openCycle(q, 1'b1, fifoData[0]);
							d.shift = fifoData;
						end
					end
				end
			endcase
		end
	end

	// Outputs idle high, recovery wait armed from reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q       <= '0;
			q.st    <= HCU_IDLE;
			q.stage <= HCU_OPEN;
			q.timer <= RecLoad;
			q.ceN   <= 1'b1;
			q.oeN   <= 1'b1;
			q.weN   <= 1'b1;
		end else begin
			q <= d;
		end
	end
endmodule : hcu_host

`default_nettype wire

// >>> hcu_host_props.sv
// Checker on the host's pin and command ports
`timescale 1ns/1ps
`default_nettype none
`include "hcu_cfg.svh"
module hcu_host_props (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       powerOk,
	input wire logic       cmdValid,
	input wire logic       cmdReady,
	input wire logic       busy,
	input wire logic       abort,
	input wire logic       ceN,
	input wire logic       oeN,
	input wire logic       weN,
	input wire logic [7:0] dqOut,
	input wire logic       dqOe
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Supply loss deselects at once and kills the sequence
	AST_PF_DESELECT: assert property (!powerOk |-> ceN && !dqOe)
		else $error("active while supply low");
	AST_PF_ABORT: assert property (busy && $fell(powerOk) |-> ##[0:2] abort)
		else $error("no abort on power loss");
	// Strobe long enough for the device, then a real gap
	AST_STROBE: assert property ($rose(ceN) && powerOk |-> !$past(ceN, 11))
		else $error("strobe too short");
	AST_GAP: assert property ($rose(ceN) |=> ceN [*2])
		else $error("gap too short");
	AST_ONE_STROBE: assert property (oeN || weN)
		else $error("both strobes low");
	AST_WR_DRIVE: assert property (!ceN && !weN |-> dqOe)
		else $error("write without data");
	// Data must not move as the write ends
	AST_DQ_HOLD: assert property ($rose(ceN) && dqOe |=> $stable(dqOut) || !powerOk)
		else $error("data moved at strobe end");
	AST_OPEN_READ: assert property (cmdValid && cmdReady |-> ##[1:2] !ceN && !oeN)
		else $error("no opening read");
endmodule : hcu_host_props
bind hcu_host hcu_host_props u_hcu_host_props (.clk(clk), .rst_n(rst_n), .powerOk(powerOk),
	.cmdValid(cmdValid), .cmdReady(cmdReady), .busy(busy), .abort(abort), .ceN(ceN),
	.oeN(oeN), .weN(weN), .dqOut(dqOut), .dqOe(dqOe));
`default_nettype wire

// >>> hcu_dev_model.sv
// Device model: unlock pattern check and hidden bit transfer
`timescale 1ns/1ps
`default_nettype none
`include "hcu_cfg.svh"
module hcu_dev_model #(
	parameter logic [63:0] Pattern = `HCU_PATTERN,
	parameter logic [63:0] Init    = 64'h0
) (
	input  wire logic        ceN,
	input  wire logic        oeN,
	input  wire logic        weN,
	input  wire logic        powerOk,
	input  wire logic [7:0]  dqOut,
	output logic      [7:0]  dqIn,
	output logic      [63:0] regs,
	output int               hits
);
	logic [6:0] ptr = 7'h00;
	logic [5:0] idx = 6'h00;
	logic       stall = 1'b0;
	logic       isRd = 1'b0;
	wire logic  act = !ceN && powerOk && !(oeN && weN);
	initial regs = Init;
	initial hits = 0;
	// Bit 0 driven only by an unlocked read; otherwise the inverse shows
	assign dqIn = (act && !oeN && ptr[6]) ? {7'h00, regs[idx]} : {8{!regs[idx]}};
	always @(posedge act)
		isRd = !oeN;
	// A cycle ends at the earlier rise of select or strobe
	always @(negedge act) begin
		if (powerOk) begin
			if (ptr[6]) begin // Reg 0 bit 0 first, one bit a cycle
				if (!isRd)
					regs[idx] = dqOut[0];
				idx = idx + 6'h01;
				ptr = (idx == 6'h00) ? 7'h00 : ptr; // Fresh unlock after 64
				hits = hits + int'(idx == 6'h00);
			end else if (isRd) begin // Read restarts, any address
				ptr = 7'h00;
				stall = 1'b0;
			end else if (!stall && dqOut[0] == Pattern[ptr[5:0]]) // LSB first
				ptr = ptr + 7'h01;
			else
				stall = 1'b1;
		end
	end
endmodule : hcu_dev_model
`default_nettype wire

// >>> tb_hcu_host.sv
// Self-checking bench for the hidden clock unlock host
`timescale 1ns/1ps
`default_nettype none
`include "hcu_cfg.svh"
module tb_hcu_host;
	localparam logic [63:0] Init = 64'h2301_1504_3059_4512;
	localparam logic [63:0] ValA = 64'h7766_5544_3322_1100;
	localparam logic [63:0] ValB = 64'hFFEE_DDCC_BBAA_9988;
	logic        clk = 1'b0, rst_n = 1'b0, powerOk = 1'b0, cmdValid = 1'b0;
	logic        cmdWrite = 1'b0, wrValid = 1'b0, cmdReady, wrReady, rdValid;
	logic        busy, done, abort, ceN, oeN, weN, dqOe;
	logic [7:0]  wrData = 8'h00, rdData, dqOut, dqIn;
	logic [16:0] addr, scratchAddr = 17'h1_FFF0; // One scratch place
	logic [63:0] regs, got;
	int          errors = 0, n_tests = 0, hits, expHits = 0, k;
	always #4 clk = ~clk;
	hcu_host #(.RecoveryCycles(20)) u_hcu_host (.clk(clk), .rst_n(rst_n), .powerOk(powerOk),
		.scratchAddr(scratchAddr), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
		.cmdReady(cmdReady), .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady),
		.rdData(rdData), .rdValid(rdValid), .busy(busy), .done(done), .abort(abort),
		.ceN(ceN), .oeN(oeN), .weN(weN), .addr(addr), .dqOut(dqOut), .dqOe(dqOe),
		.dqIn(dqIn));
	hcu_dev_model #(.Init(Init)) u_hcu_dev_model (.ceN(ceN), .oeN(oeN), .weN(weN),
		.powerOk(powerOk), .dqOut(dqOut), .dqIn(dqIn), .regs(regs), .hits(hits));
	task automatic summarize();
		if (errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [63:0] a, input logic [63:0] b);
		n_tests++;
		if (a !== b) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, a, b);
		end
	endtask : chk
	// Bounded wait; a hang ends the run
	task automatic waitHi(ref logic s, input int lim);
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (s !== 1'b1 && k < lim);
		if (s !== 1'b1) begin
			errors++;
			$display("mismatch at %0t: timeout", $time);
			summarize();
		end
	endtask : waitHi
	task automatic issue(input logic wr);
		waitHi(cmdReady, 100);
		cmdValid <= 1'b1;
		cmdWrite <= wr;
		@(posedge clk);
		cmdValid <= 1'b0;
	endtask : issue
	// Collect read bytes until done, byte 0 ends lowest
	task automatic complete();
		got = 64'h0;
		waitHi(busy, 4);
		chk(cmdReady, 1'b0);
		chk(addr, scratchAddr);
		for (k = 0; k < 3000 && done !== 1'b1; k++) begin
			@(posedge clk);
			if (rdValid === 1'b1)
				got = {rdData, got[63:8]};
		end
		expHits++;
		chk({k < 3000, hits}, {1'b1, expHits});
		// A stalled transfer ends the run at once
		if (k >= 3000)
			summarize();
	endtask : complete
	task automatic scReset();
		chk({ceN, oeN, weN, dqOe, cmdReady}, 5'h1C);
		powerOk <= 1'b1;
		waitHi(cmdReady, 60);
		chk(k >= 20, 1'b1);
	endtask : scReset
	task automatic scRead(input logic [63:0] exp);
		issue(1'b0);
		complete();
		chk(got, exp);
	endtask : scRead
	// Fill the buffer to refusal, two writes drain it, read back
	task automatic scWrite();
		for (int i = 0; i < 16; i++) begin
			wrData <= 8'h11 * 8'(i);
			wrValid <= 1'b1;
			@(posedge clk);
		end
		wrValid <= 1'b0;
		@(posedge clk);
		chk(wrReady, 1'b0);
		issue(1'b1);
		complete();
		chk(regs, ValA);
		chk(regs[37:36], 2'b00);
		issue(1'b1);
		complete();
		chk(regs, ValB);
		chk(wrReady, 1'b1);
		scRead(ValB);
	endtask : scWrite
	// Supply loss mid-unlock; next command must unlock afresh
	task automatic scPower();
		issue(1'b0);
		repeat (300) @(posedge clk);
		powerOk <= 1'b0;
		waitHi(abort, 4);
		chk({ceN, dqOe, cmdReady}, 3'h4);
		powerOk <= 1'b1;
		scRead(ValB);
	endtask : scPower
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		scReset();
		scRead(Init);
		scWrite();
		scPower();
		summarize();
	end
endmodule : tb_hcu_host
`default_nettype wire
